// File: rtl/fw_cmd_handler.sv
// Firmware upgrade and event log command handler with an AXI4-Lite register slave.
//
// Our own choices: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
module fw_cmd_handler #(
    parameter int unsigned APP_BYTES = fw_pkg::APP_BYTES_DEF,
    parameter int unsigned LOG_GATHER_CYCLES = 32'(fw_pkg::LOG_GATHER_CYCLES)
) (
    input wire logic sys_clk_i,
    input wire logic rstn_i,
    input wire logic rx_valid_i,
    input wire logic rx_first_i,
    input wire logic [7:0] rx_data_i,
    input wire logic rx_end_i,
    input wire logic rx_pec_ok_i,
    input wire logic tx_start_i,
    input wire logic tx_ready_i,
    output logic tx_valid_o,
    output logic [7:0] tx_data_o,
    output logic tx_last_o,
    output logic main_out_on_o,
    output logic app_run_o,
    input wire logic [7:0] s_axi_awaddr_i,
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    output logic [1:0] s_axi_bresp_o,
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    input wire logic [7:0] s_axi_araddr_i,
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    output logic [31:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i
);

    // ----------------------------------------
    // State
    // ----------------------------------------
    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
        logic aw_got;
        logic w_got;
        logic [7:0] aw_addr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic out_req;
        logic out_on;
        logic [31:0] snap;
        logic [31:0] stamp;
        logic in_boot;
        logic app_run;
        logic erased;
        logic crc_bad;
        logic seq_err;
        logic addr_err;
        logic [2:0] valid;
        logic [1:0] tgt;
        logic [15:0] seq;
        logic [15:0] crc;
        logic [15:0] tail;
        logic [1:0] tail_n;
        logic [31:0] app_cnt;
        logic [7:0] cmd;
        logic [7:0] p1;
        logic [7:0] p2;
        logic [7:0] p3;
        logic [7:0] p4;
        logic [5:0] idx;
        logic [fw_pkg::LOG_BYTES-1:0][7:0] log;
        logic [2:0] wr_rec;
        logic [15:0] log_addr;
        logic [7:0] log_len;
        logic [31:0] gather;
        fw_pkg::tx_state_e tx;
        logic [5:0] tx_cnt;
        logic [5:0] tx_len;
        logic tx_valid;
        logic tx_last;
        logic [7:0] tx_data;
    } state_s;

    state_s s;
    state_s n;
    logic [15:0] crc_next;
    logic log_trig;
    logic [1:0] t;
    int base;

    crc16_byte_step u_crc (
        .crc_i(s.crc),
        .data_i(s.tail[15:8]),
        .crc_o(crc_next)
    );

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [1:0] tgt_index(input logic [7:0] code);
        logic [1:0] r;
        r = 2'h3;
        if (code == fw_pkg::TGT_INPUT) r = 2'h0;
        if (code == fw_pkg::TGT_SECONDARY) r = 2'h1;
        if (code == fw_pkg::TGT_BUS) r = 2'h2;
        return r;
    endfunction

    function automatic logic [7:0] status_byte(input state_s x);
        logic [7:0] r;
        r = 8'h00;
        r[fw_pkg::ST_ERASED] = x.erased;
        r[fw_pkg::ST_CRC_BAD] = x.crc_bad;
        r[fw_pkg::ST_SEQ_ERR] = x.seq_err;
        r[fw_pkg::ST_ADDR_ERR] = x.addr_err;
        r[fw_pkg::ST_IN_BOOT] = x.in_boot;
        return r;
    endfunction

    // The window must lie inside the log and the gather delay must have run out.
    function automatic logic log_ok(input state_s x);
        return x.gather >= LOG_GATHER_CYCLES && x.log_len <= fw_pkg::MAX_PACKET
            && 32'(x.log_addr) + 32'(x.log_len) <= 32'(fw_pkg::LOG_BYTES);
    endfunction

    function automatic logic [5:0] resp_last(input state_s x);
        logic [5:0] r;
        r = 6'h00;
        if (x.cmd == fw_pkg::CMD_DATA) r = fw_pkg::DATA_RESP_LAST;
        if (x.cmd == fw_pkg::CMD_LOG && log_ok(x)) r = x.log_len[5:0];
        return r;
    endfunction

    function automatic logic [7:0] resp_byte(input state_s x, input logic [5:0] i);
        logic [7:0] r;
        int a;
        r = fw_pkg::NO_DATA;
        a = 32'(x.log_addr) + 32'(i) - 1;
        case (x.cmd)
            fw_pkg::CMD_STATUS, fw_pkg::CMD_APP_STATUS: r = status_byte(x);
            fw_pkg::CMD_DATA: begin
                case (i)
                    6'h00: r = fw_pkg::DATA_RESP_COUNT;
                    6'h01: r = x.seq[7:0];
                    6'h02: r = x.seq[15:8];
                    default: r = status_byte(x);
                endcase
            end
            fw_pkg::CMD_LOG: begin
                if (!log_ok(x)) r = 8'h00;
                else if (i == 6'h00) r = x.log_len;
                else if (a < fw_pkg::LOG_BYTES) r = x.log[a];
            end
            default: r = fw_pkg::NO_DATA;
        endcase
        return r;
    endfunction

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        n = s;
        log_trig = 1'b0;
        t = tgt_index(s.p1);
        base = 32'(s.wr_rec) * fw_pkg::RECORD_BYTES;
        n.stamp = s.stamp + 32'h1;
        if (s.gather < LOG_GATHER_CYCLES) n.gather = s.gather + 32'h1;

        // Register writes take address and data in either order.
        if (s.awready && s_axi_awvalid_i) begin
            n.aw_got = 1'b1;
            n.aw_addr = s_axi_awaddr_i;
        end
        if (s.wready && s_axi_wvalid_i) begin
            n.w_got = 1'b1;
            n.wdata = s_axi_wdata_i;
            n.wstrb = s_axi_wstrb_i;
        end
        if (s.bvalid && s_axi_bready_i) n.bvalid = 1'b0;
        if (n.aw_got && n.w_got && !n.bvalid) begin
            n.aw_got = 1'b0;
            n.w_got = 1'b0;
            n.bvalid = 1'b1;
            n.bresp = fw_pkg::RESP_OKAY;
            case (n.aw_addr)
                fw_pkg::ADDR_CTRL: begin
                    if (n.wstrb[0]) begin
                        n.out_req = n.wdata[fw_pkg::CTRL_OUT_ON];
                        log_trig = n.wdata[fw_pkg::CTRL_LOG_TRIG];
                    end
                end
                fw_pkg::ADDR_SNAP: begin
                    for (int k = 0; k < 4; k++) begin
                        if (n.wstrb[k]) n.snap[8*k+:8] = n.wdata[8*k+:8];
                    end
                end
                fw_pkg::ADDR_STATUS, fw_pkg::ADDR_CRC: n.bresp = fw_pkg::RESP_OKAY;
                default: n.bresp = fw_pkg::RESP_SLVERR;
            endcase
        end
        n.awready = !n.aw_got && !n.bvalid;
        n.wready = !n.w_got && !n.bvalid;

        if (s.rvalid && s_axi_rready_i) n.rvalid = 1'b0;
        if (s.arready && s_axi_arvalid_i) begin
            n.rvalid = 1'b1;
            n.rresp = fw_pkg::RESP_OKAY;
            n.rdata = 32'h0;
            case (s_axi_araddr_i)
                fw_pkg::ADDR_CTRL: n.rdata[fw_pkg::CTRL_OUT_ON] = s.out_req;
                fw_pkg::ADDR_SNAP: n.rdata = s.snap;
                fw_pkg::ADDR_STATUS: n.rdata = {3'h0, s.out_on, s.app_run, s.valid, s.seq, status_byte(s)};
                fw_pkg::ADDR_CRC: n.rdata = {s.tail, s.crc};
                default: n.rresp = fw_pkg::RESP_SLVERR;
            endcase
        end
        n.arready = !n.rvalid;

        // A trigger stores timestamp then snapshot, wrapping onto the oldest record.
        if (log_trig) begin
            for (int k = 0; k < fw_pkg::RECORD_BYTES; k++) begin
                n.log[base + k] = (k < 4) ? s.stamp[8*k+:8] : s.snap[8*(k%4)+:8];
            end
            n.wr_rec = (32'(s.wr_rec) == fw_pkg::LOG_RECORDS - 1) ? 3'h0 : s.wr_rec + 3'h1;
        end

        // Incoming write frame, one byte per beat.
        if (rx_valid_i) begin
            if (rx_first_i) begin
                n.cmd = rx_data_i;
                n.idx = 6'h01;
            end else begin
                case (s.idx)
                    6'h01: n.p1 = rx_data_i;
                    6'h02: n.p2 = rx_data_i;
                    6'h03: n.p3 = rx_data_i;
                    6'h04: n.p4 = rx_data_i;
                    default: n.p4 = s.p4;
                endcase
                // Payload enters the check only while the sequence matches.
                if (s.cmd == fw_pkg::CMD_DATA && s.in_boot && s.idx >= fw_pkg::PAYLOAD_IDX
                    && {2'h0, 6'(s.idx - fw_pkg::PAYLOAD_IDX)} < s.p4 && s.p4 <= fw_pkg::MAX_PACKET
                    && {s.p3, s.p2} == s.seq) begin
                    if (s.app_cnt >= APP_BYTES) begin
                        n.addr_err = 1'b1;
                    end else begin
                        // The last two bytes stay out of the running value for the compare.
                        n.app_cnt = s.app_cnt + 32'h1;
                        if (s.tail_n == 2'h2) n.crc = crc_next;
                        n.tail = {s.tail[7:0], rx_data_i};
                        if (s.tail_n != 2'h2) n.tail_n = s.tail_n + 2'h1;
                    end
                end
                if (s.idx != 6'h3f) n.idx = s.idx + 6'h01;
            end
        end

        // Commands act at frame end once the packet check has passed.
        if (rx_end_i && rx_pec_ok_i) begin
            if (s.cmd == fw_pkg::CMD_BOOT && s.idx >= 6'h03) begin
                case (s.p2)
                    fw_pkg::BOOT_ENTER: begin
                        n.in_boot = 1'b1;
                        n.app_run = 1'b0;
                    end
                    fw_pkg::BOOT_ERASE: begin
                        if (s.in_boot && t != 2'h3) begin
                            n.tgt = t;
                            n.valid[t] = 1'b0;
                            n.erased = 1'b1;
                            n.crc_bad = 1'b0;
                            n.seq_err = 1'b0;
                            n.addr_err = 1'b0;
                            n.seq = 16'h0000;
                            n.crc = fw_pkg::CRC_INIT;
                            n.tail_n = 2'h0;
                            n.app_cnt = 32'h0;
                        end else if (s.in_boot) begin
                            n.addr_err = 1'b1;
                        end
                    end
                    fw_pkg::BOOT_DONE: begin
                        if (s.in_boot && s.tail_n == 2'h2 && s.crc == s.tail && !s.seq_err && !s.addr_err) begin
                            n.valid[s.tgt] = 1'b1;
                            n.erased = 1'b0;
                            n.crc_bad = 1'b0;
                        end else if (s.in_boot) begin
                            n.crc_bad = 1'b1;
                        end
                    end
                    fw_pkg::BOOT_EXIT: begin
                        if (s.in_boot && &s.valid && status_byte(s) == 8'h80) begin
                            n.in_boot = 1'b0;
                            n.app_run = 1'b1;
                        end
                    end
                    default: n.cmd = s.cmd;
                endcase
            end
            if (s.cmd == fw_pkg::CMD_DATA && s.idx >= fw_pkg::PAYLOAD_IDX && s.in_boot) begin
                if ({s.p3, s.p2} != s.seq || s.p4 > fw_pkg::MAX_PACKET) n.seq_err = 1'b1;
                else n.seq = s.seq + 16'h0001;
            end
            if (s.cmd == fw_pkg::CMD_LOG && s.idx >= 6'h04) begin
                n.log_addr = {s.p1, s.p2};
                n.log_len = s.p3;
                n.gather = 32'h0;
            end
        end

        // Read answer for the command last written.
        unique case (s.tx)
            fw_pkg::TX_IDLE: begin
                if (tx_start_i) begin
                    n.tx = fw_pkg::TX_SEND;
                    n.tx_cnt = 6'h00;
                    n.tx_len = resp_last(s);
                    n.tx_valid = 1'b1;
                    n.tx_data = resp_byte(s, 6'h00);
                    n.tx_last = resp_last(s) == 6'h00;
                end
            end
            fw_pkg::TX_SEND: begin
                if (tx_ready_i && s.tx_last) begin
                    n.tx = fw_pkg::TX_IDLE;
                    n.tx_valid = 1'b0;
                    n.tx_last = 1'b0;
                end else if (tx_ready_i) begin
                    n.tx_cnt = s.tx_cnt + 6'h01;
                    n.tx_data = resp_byte(s, s.tx_cnt + 6'h01);
                    n.tx_last = (s.tx_cnt + 6'h01) == s.tx_len;
                end
            end
        endcase

        n.out_on = n.out_req && !n.in_boot;
    end

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            s <= '0;
            s.crc <= fw_pkg::CRC_INIT;
            s.valid <= 3'h7;
            s.app_run <= 1'b1;
            s.awready <= 1'b1;
            s.wready <= 1'b1;
            s.arready <= 1'b1;
            s.tx <= fw_pkg::TX_IDLE;
        end else begin
            s <= n;
        end
    end

    assign tx_valid_o = s.tx_valid;
    assign tx_data_o = s.tx_data;
    assign tx_last_o = s.tx_last;
    assign main_out_on_o = s.out_on;
    assign app_run_o = s.app_run;
    assign s_axi_awready_o = s.awready;
    assign s_axi_wready_o = s.wready;
    assign s_axi_bresp_o = s.bresp;
    assign s_axi_bvalid_o = s.bvalid;
    assign s_axi_arready_o = s.arready;
    assign s_axi_rdata_o = s.rdata;
    assign s_axi_rresp_o = s.rresp;
    assign s_axi_rvalid_o = s.rvalid;

endmodule

// File: rtl/fw_pkg.sv
// Constants for the firmware upgrade and event log command handler.
// What this block does
// - Boot control write carries command, target byte, one data byte and a packet check.
// - Boot data 1 enters, 2 erases, 3 marks upload done, 4 exits.
// - The target byte is ignored for enter and exit requests.
// - Entering the boot loader switches the main output off.
// - After erase the status reads in-boot plus erased, and the host checks it.
// - Data write carries target, sequence low then high, count up to 32, payload.
// - Each accepted data packet increments the stored sequence number.
// - Data read returns count, sequence low, sequence high and the status byte.
// - Done request compares CRC-16 of the image with its final two bytes.
// - A passing check leaves status as in-boot with no error bits.
// - Exit takes effect only when every application image is valid.
// - After exit the application runs and status reads zero.
// - The application is not started when reprogramming saw any error.
// - Event log keeps five records; a new record overwrites the oldest.
// - A log trigger stores a record of timestamp and snapshot state.
// - Log upload write gives address high, low and length; read follows after 100 ms.
// - On a bad request or data not yet gathered the read returns length zero.
// - The application status read returns one status byte.
// - Status bits: 0x01 erased, 0x02 CRC bad, 0x04 sequence, 0x08 address, 0x80 boot.
package fw_pkg;

    // ----------------------------------------
    // Command codes and boot requests
    // ----------------------------------------
    localparam logic [7:0] CMD_STATUS = 8'he1;
    localparam logic [7:0] CMD_APP_STATUS = 8'he5;
    localparam logic [7:0] CMD_BOOT = 8'he6;
    localparam logic [7:0] CMD_DATA = 8'he7;
    localparam logic [7:0] CMD_LOG = 8'hf0;
    localparam logic [7:0] BOOT_ENTER = 8'h01;
    localparam logic [7:0] BOOT_ERASE = 8'h02;
    localparam logic [7:0] BOOT_DONE = 8'h03;
    localparam logic [7:0] BOOT_EXIT = 8'h04;
    localparam logic [7:0] NO_DATA = 8'hff;

    // ----------------------------------------
    // Targets, status bits and packet layout
    // ----------------------------------------
    localparam logic [7:0] TGT_INPUT = 8'h70;
    localparam logic [7:0] TGT_SECONDARY = 8'h73;
    localparam logic [7:0] TGT_BUS = 8'h69;
    localparam int ST_ERASED = 0;
    localparam int ST_CRC_BAD = 1;
    localparam int ST_SEQ_ERR = 2;
    localparam int ST_ADDR_ERR = 3;
    localparam int ST_IN_BOOT = 7;
    localparam logic [7:0] MAX_PACKET = 8'h20;
    localparam logic [5:0] PAYLOAD_IDX = 6'h05;
    localparam logic [5:0] DATA_RESP_LAST = 6'h03;
    localparam logic [7:0] DATA_RESP_COUNT = 8'h03;
    localparam logic [15:0] CRC_INIT = 16'hffff;
    localparam logic [15:0] CRC_POLY = 16'h1021;
    localparam int unsigned APP_BYTES_DEF = 32768;

    // ----------------------------------------
    // Event log and timing
    // ----------------------------------------
    localparam int LOG_RECORDS = 5;
    localparam int RECORD_BYTES = 8;
    localparam int LOG_BYTES = LOG_RECORDS * RECORD_BYTES;
    localparam longint unsigned CLK_HZ = 64'd100000000;
    localparam longint unsigned LOG_GATHER_MS = 64'd100;
    localparam longint unsigned LOG_GATHER_CYCLES = (LOG_GATHER_MS * CLK_HZ) / 64'd1000;

    // ----------------------------------------
    // Register map
    // ----------------------------------------
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_SNAP = 8'h04;
    localparam logic [7:0] ADDR_STATUS = 8'h08;
    localparam logic [7:0] ADDR_CRC = 8'h0c;
    localparam int CTRL_OUT_ON = 0;
    localparam int CTRL_LOG_TRIG = 1;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [0:0] {TX_IDLE, TX_SEND} tx_state_e;

endpackage

// File: rtl/crc16_byte_step.sv
// One byte step of the CRC-16 used to check an uploaded application image.
`timescale 1ns/10ps
module crc16_byte_step (
    input wire logic [15:0] crc_i,
    input wire logic [7:0] data_i,
    output logic [15:0] crc_o
);

    logic [15:0] c;

    always_comb begin
        c = crc_i ^ {data_i, 8'h00};
        for (int b = 0; b < 8; b++) begin
            c = c[15] ? ({c[14:0], 1'b0} ^ fw_pkg::CRC_POLY) : {c[14:0], 1'b0};
        end
        crc_o = c;
    end

endmodule

// File: tb/fw_cmd_handler_assertions.sv
// Port checks for the command handler.
`timescale 1ns/10ps
module fw_cmd_checker (
    input wire logic sys_clk_i,
    input wire logic rstn_i,
    input wire logic tx_start_i,
    input wire logic tx_ready_i,
    input wire logic tx_valid_o,
    input wire logic [7:0] tx_data_o,
    input wire logic tx_last_o,
    input wire logic main_out_on_o,
    input wire logic app_run_o,
    input wire logic s_axi_awvalid_i,
    input wire logic s_axi_awready_o,
    input wire logic s_axi_wvalid_i,
    input wire logic s_axi_wready_o,
    input wire logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    input wire logic s_axi_arvalid_i,
    input wire logic s_axi_arready_o,
    input wire logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!rstn_i);
    wr_answer_a: assert property (s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o
        |=> s_axi_bvalid_o) else $error("write answer missing");
    wr_block_a: assert property (s_axi_bvalid_o |-> !s_axi_awready_o && !s_axi_wready_o)
        else $error("write accepted while answer pending");
    wr_release_a: assert property (s_axi_bvalid_o && s_axi_bready_i |=> !s_axi_bvalid_o && s_axi_awready_o)
        else $error("write answer not released");
    rd_answer_a: assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o && !s_axi_arready_o)
        else $error("read answer missing");
    rd_release_a: assert property (s_axi_rvalid_o && s_axi_rready_i |=> !s_axi_rvalid_o && s_axi_arready_o)
        else $error("read answer not released");
    tx_hold_a: assert property (tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_data_o))
        else $error("link byte changed while stalled");
    tx_answer_a: assert property (tx_start_i && !tx_valid_o |=> tx_valid_o)
        else $error("link answer late");
    tx_end_a: assert property (tx_valid_o && tx_last_o && tx_ready_i |=> !tx_valid_o)
        else $error("link answer overran");
    out_off_a: assert property (!app_run_o |-> !main_out_on_o)
        else $error("output on in boot loader");
endmodule

bind fw_cmd_handler fw_cmd_checker chk_u (.sys_clk_i, .rstn_i, .tx_start_i, .tx_ready_i, .tx_valid_o,
    .tx_data_o, .tx_last_o, .main_out_on_o, .app_run_o, .s_axi_awvalid_i, .s_axi_awready_o,
    .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_arvalid_i,
    .s_axi_arready_o, .s_axi_rvalid_o, .s_axi_rready_i);

// File: tb/host_model.sv
// Host end of the management link.
`timescale 1ns/10ps
module host_model (
    input wire logic clk_i,
    input wire logic tx_valid_i,
    input wire logic tx_last_i,
    output logic rx_valid_o,
    output logic rx_first_o,
    output logic [7:0] rx_data_o,
    output logic rx_end_o,
    output logic rx_pec_ok_o,
    output logic tx_start_o,
    output logic tx_ready_o
);
    logic [2:0] cnt = 3'h0;
    initial begin
        {rx_valid_o, rx_first_o, rx_end_o, rx_pec_ok_o, tx_start_o} = '0;
        rx_data_o = 8'h00;
    end
    // Stalls on some answer bytes, so slow hosts are covered too.
    always @(posedge clk_i) cnt <= cnt + 3'h1;
    assign tx_ready_o = cnt[0] | cnt[2];
    task automatic send(input logic [7:0] b[$]);
        foreach (b[i]) begin
            rx_valid_o <= 1'b1;
            rx_first_o <= (i == 0);
            rx_data_o <= b[i];
            @(posedge clk_i);
        end
        rx_valid_o <= 1'b0;
        rx_first_o <= 1'b0;
        // A released data line must not keep looking like the last byte.
        rx_data_o <= ~b[b.size() - 1];
        {rx_end_o, rx_pec_ok_o} <= 2'h3;
        @(posedge clk_i);
        {rx_end_o, rx_pec_ok_o} <= 2'h0;
        @(posedge clk_i);
    endtask
    task automatic fetch(output logic ok);
        tx_start_o <= 1'b1;
        @(posedge clk_i);
        tx_start_o <= 1'b0;
        ok = 1'b0;
        for (int n = 0; n < 200 && !ok; n++) begin
            @(posedge clk_i);
            ok = tx_valid_i & tx_last_i & tx_ready_o;
        end
        @(posedge clk_i);
    endtask
endmodule

// File: tb/tb.sv
// Self-checking bench for the upgrade and event log handler.
`timescale 1ns/10ps
module tb;
    localparam int GATHER = 20;
    logic sys_clk_i, rstn_i, rx_valid_i, rx_first_i, rx_end_i, rx_pec_ok_i, tx_start_i, tx_ready_i, ok;
    logic tx_valid_o, tx_last_o, main_out_on_o, app_run_o, s_axi_awvalid_i, s_axi_awready_o, s_axi_wvalid_i;
    logic s_axi_wready_o, s_axi_bvalid_o, s_axi_bready_i, s_axi_arvalid_i, s_axi_arready_o, s_axi_rvalid_o;
    logic s_axi_rready_i;
    logic [7:0] rx_data_i, tx_data_o, s_axi_awaddr_i, s_axi_araddr_i;
    logic [31:0] s_axi_wdata_i, s_axi_rdata_o, seed, snap[6];
    logic [3:0] s_axi_wstrb_i;
    logic [1:0] s_axi_bresp_o, s_axi_rresp_o;
    logic [7:0] img[64], pkt[$];
    logic [15:0] crc;
    logic [31:0] exp_q[$];
    int n_fail = 0, n_checks = 0;
    fw_cmd_handler #(.APP_BYTES(64), .LOG_GATHER_CYCLES(GATHER)) uut (.*);
    host_model hm (.clk_i(sys_clk_i), .tx_valid_i(tx_valid_o), .tx_last_i(tx_last_o), .rx_valid_o(rx_valid_i),
        .rx_first_o(rx_first_i), .rx_data_o(rx_data_i), .rx_end_o(rx_end_i), .rx_pec_ok_o(rx_pec_ok_i),
        .tx_start_o(tx_start_i), .tx_ready_o(tx_ready_i));
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR %0t seen %h expected %h", $time, got, exp);
        end
    endtask
    task automatic complete_run();
        $display("checks %0d failures %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic timeout();
        chk(32'h0, 32'h1);
        complete_run();
    endtask
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
        int n;
        exp_q.push_back({30'h0, fw_pkg::RESP_OKAY});
        {s_axi_awaddr_i, s_axi_wdata_i} <= {a, d};
        {s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i} <= 3'h7;
        for (n = 0; n < 50 && s_axi_bvalid_o !== 1'b1; n++) begin
            @(posedge sys_clk_i);
            if (s_axi_awready_o) s_axi_awvalid_i <= 1'b0;
            if (s_axi_wready_o) s_axi_wvalid_i <= 1'b0;
        end
        if (n == 50) timeout();
        @(posedge sys_clk_i);
    endtask
    task automatic axi_rd(input logic [7:0] a, input logic [31:0] e);
        int n;
        exp_q.push_back(e);
        {s_axi_araddr_i, s_axi_arvalid_i, s_axi_rready_i} <= {a, 2'h3};
        for (n = 0; n < 50 && s_axi_rvalid_o !== 1'b1; n++) begin
            @(posedge sys_clk_i);
            if (s_axi_arready_o) s_axi_arvalid_i <= 1'b0;
        end
        if (n == 50) timeout();
        @(posedge sys_clk_i);
    endtask
    task automatic ask(input logic [7:0] e[$]);
        foreach (e[i]) exp_q.push_back({24'h0, e[i]});
        hm.fetch(ok);
        if (ok !== 1'b1) timeout();
    endtask
    task automatic logrd(input logic [7:0] a, input logic [7:0] n, input logic [31:0] v);
        hm.send('{fw_pkg::CMD_LOG, 8'h00, a, n});
        ask('{8'h00});
        repeat (GATHER) @(posedge sys_clk_i);
        if (n > 8'h20 || a + n > 8'd40) ask('{8'h00});
        else ask('{n, v[7:0], v[15:8], v[23:16], v[31:24]});
    endtask
    // Answers arrive in request order, so one queue serves all three paths: register read, register write and link.
    always @(posedge sys_clk_i) begin
        if (s_axi_rvalid_o === 1'b1 && s_axi_rready_i) chk({s_axi_rresp_o, s_axi_rdata_o[29:0]}, exp_q.pop_front());
        if (s_axi_bvalid_o === 1'b1 && s_axi_bready_i) chk({30'h0, s_axi_bresp_o}, exp_q.pop_front());
        if (tx_valid_o === 1'b1 && tx_ready_i) chk({24'h0, tx_data_o}, exp_q.pop_front());
    end
    initial begin
        sys_clk_i = 1'b0;
        forever #5 sys_clk_i = ~sys_clk_i;
    end
    initial begin
        {rstn_i, s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i, s_axi_arvalid_i, s_axi_rready_i} = '0;
        {s_axi_awaddr_i, s_axi_araddr_i, s_axi_wdata_i, s_axi_wstrb_i} = {48'h0, 4'hf};
        seed = 32'hc522d8d1;
        foreach (img[i]) img[i] = 8'(rnd());
        crc = fw_pkg::CRC_INIT;
        for (int i = 0; i < 62; i++) begin
            crc ^= {img[i], 8'h00};
            repeat (8) crc = crc[15] ? (crc << 1) ^ fw_pkg::CRC_POLY : crc << 1;
        end
        // The first pass carries a wrong check value on purpose.
        {img[62], img[63]} = crc ^ 16'h0001;
        repeat (3) @(posedge sys_clk_i);
        rstn_i <= 1'b1;
        @(posedge sys_clk_i);
        axi_rd(fw_pkg::ADDR_STATUS, 32'h0f00_0000);
        axi_rd(8'h10, 32'h8000_0000);
        axi_wr(fw_pkg::ADDR_CTRL, 32'h1);
        hm.send('{fw_pkg::CMD_BOOT, 8'h55, fw_pkg::BOOT_ENTER});
        axi_rd(fw_pkg::ADDR_STATUS, 32'h0700_0080);
        for (int p = 0; p < 2; p++) begin
            hm.send('{fw_pkg::CMD_BOOT, fw_pkg::TGT_INPUT, fw_pkg::BOOT_ERASE});
            repeat (4) @(posedge sys_clk_i);
            hm.send('{fw_pkg::CMD_APP_STATUS, fw_pkg::TGT_INPUT});
            ask('{8'h81});
            if (p == 0) begin
                hm.send('{fw_pkg::CMD_DATA, fw_pkg::TGT_INPUT, 8'h05, 8'h00, 8'h01, 8'haa});
                hm.send('{fw_pkg::CMD_DATA});
                ask('{8'h03, 8'h00, 8'h00, 8'h85});
            end
            for (int k = 0; k < 2; k++) begin
                pkt = '{fw_pkg::CMD_DATA, fw_pkg::TGT_INPUT, 8'(k), 8'h00, 8'h20};
                for (int j = 0; j < 32; j++) pkt.push_back(img[k * 32 + j]);
                hm.send(pkt);
                hm.send('{fw_pkg::CMD_DATA});
                ask('{8'h03, 8'(k + 1), 8'h00, p ? 8'h81 : 8'h85});
            end
            hm.send('{fw_pkg::CMD_BOOT, fw_pkg::TGT_INPUT, fw_pkg::BOOT_DONE});
            repeat (4) @(posedge sys_clk_i);
            hm.send('{fw_pkg::CMD_APP_STATUS, fw_pkg::TGT_INPUT});
            ask('{p ? 8'h80 : 8'h87});
            hm.send('{fw_pkg::CMD_BOOT, 8'h00, fw_pkg::BOOT_EXIT});
            hm.send('{fw_pkg::CMD_STATUS});
            ask('{p ? 8'h00 : 8'h87});
            img[63] ^= 8'h01;
        end
        axi_rd(fw_pkg::ADDR_STATUS, 32'h1f00_0200);
        for (int i = 0; i < 6; i++) begin
            snap[i] = rnd();
            axi_wr(fw_pkg::ADDR_SNAP, snap[i]);
            axi_wr(fw_pkg::ADDR_CTRL, 32'h3);
        end
        logrd(8'h04, 8'h04, snap[5]);
        logrd(8'h0c, 8'h04, snap[1]);
        logrd(8'h00, 8'h21, 32'h0);
        logrd(8'h24, 8'h08, 32'h0);
        complete_run();
    end
endmodule
